// *** common/usie_pkg.sv ***
package usie_pkg;
  // register indices (byte-wide port, index is the address)
  localparam logic [2:0] ADDR_FUNC_ADDR = 3'h0;
  localparam logic [2:0] ADDR_EP0_CSR = 3'h1;
  localparam logic [2:0] ADDR_EP0_COUNT = 3'h2;
  localparam logic [2:0] ADDR_CTRL_FIFO = 3'h3;
  localparam logic [2:0] ADDR_IN_CSR = 3'h4;
  localparam logic [2:0] ADDR_IN_FIFO = 3'h5;
  localparam logic [2:0] ADDR_EVENT = 3'h6;
  localparam logic [2:0] ADDR_MISC = 3'h7;
  // in_ep_control_status fields
  localparam int IN_FLUSH_BIT = 7;
  localparam int IN_FORCE_EVEN_BIT = 6;
  localparam int IN_MAX_PACKET_SIZE_HI = 5;
  localparam int IN_MAX_PACKET_SIZE_LO = 2;
  localparam int IN_STALL_BIT = 1;
  localparam int IN_READY_BIT = 0;
  localparam logic [7:0] IN_CSR_RESET = 8'h20;
  // usb_event_flags fields
  localparam int EV_RESET_BIT = 4;
  localparam int EV_RESUME_BIT = 3;
  localparam int EV_SUSPEND_BIT = 2;
  localparam int EV_IN_EP_BIT = 1;
  localparam int EV_CTRL_EP_BIT = 0;
  // usb_misc_control fields
  localparam int MISC_RST_STAT_BIT = 6;
  localparam int MISC_MASK_RESET_BIT = 5;
  localparam int MISC_MASK_SUSP_BIT = 4;
  localparam int MISC_MASK_IN_BIT = 3;
  localparam int MISC_MASK_CTRL_BIT = 2;
  localparam int MISC_RESUME_REQ_BIT = 1;
  localparam int MISC_SUSPEND_BIT = 0;
  localparam logic [7:0] MISC_RESET = 8'h10;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int IDLE_SUSPEND_US = 3000;
  localparam int IDLE_SUSPEND_CYC = IDLE_SUSPEND_US * CLK_MHZ + 1;
  localparam int RESUME_HOLD_US = 10000;
  localparam int RESUME_HOLD_CYC = RESUME_HOLD_US * CLK_MHZ;
  localparam int FIFO_DEPTH = 8;
  // line state codes on the link pair: J = 01, K = 10, SE0 = 00
  localparam logic [1:0] LINE_J = 2'h1;
  localparam logic [1:0] LINE_K = 2'h2;
  localparam logic [1:0] LINE_SE0 = 2'h0;
endpackage

// *** common/usie_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// link between the serial engine and the host side: line states, packet
// transfer strobes and the control endpoint byte exchange
interface usie_if;
  logic [1:0] host_line;     // line driven by host (dp,dm); SE0 = reset
  logic host_line_oe;        // host drives the bus
  logic [1:0] dev_line;      // line driven by device
  logic dev_line_oe;         // device drives the bus
  logic in_token;            // host issues IN token to the IN endpoint
  logic in_ack;              // host acknowledges last IN data packet
  logic in_violation;        // host protocol violation on IN endpoint
  logic dev_in_valid;        // device sends an IN data byte
  logic [7:0] dev_in_data;
  logic dev_in_last;         // last byte of the packet
  logic dev_in_pid_odd;      // toggle of the packet being sent
  logic dev_in_stall;        // STALL handshake pulse
  logic dev_in_nak;          // NAK handshake pulse
  logic ctrl_wr;             // host writes a control endpoint byte
  logic [7:0] ctrl_wdata;
  logic ctrl_rd;             // host reads a control endpoint byte
  logic [7:0] ctrl_rdata;
  modport device (
    input host_line, host_line_oe, in_token, in_ack, in_violation,
    input ctrl_wr, ctrl_wdata, ctrl_rd,
    output dev_line, dev_line_oe, dev_in_valid, dev_in_data,
    output dev_in_last, dev_in_pid_odd, dev_in_stall, dev_in_nak,
    output ctrl_rdata
  );
  modport host (
    output host_line, host_line_oe, in_token, in_ack, in_violation,
    output ctrl_wr, ctrl_wdata, ctrl_rd,
    input dev_line, dev_line_oe, dev_in_valid, dev_in_data,
    input dev_in_last, dev_in_pid_odd, dev_in_stall, dev_in_nak,
    input ctrl_rdata
  );
endinterface
`default_nettype wire

// *** logic/usie_device.sv ***
// Contract
// - control endpoint byte port shared both ways
// - flush bit empties the IN FIFO
// - force bit makes next packet DATA0
// - max packet size field, default eight
// - violation sets stall, sends STALL
// - core sets/clears stall on feature requests
// - core sets ready, engine clears after ack
// - IN FIFO written by core, read by engine
// - bus reset sets event bit 4
// - resume sets event bit 3
// - suspend sets event bit 2
// - ready clear or stall set flags IN event
// - control endpoint events set event bit 0
// - reset status follows bus reset, read-only
// - masks 5..2 disable, only suspend set
// - core holds resume request ten ms
// - engine sets suspend bit for suspend
// - core clears suspend bit after wakeup
// - idle over 3 ms declares suspend
// - J-to-K while suspended raises wakeup
// - resume request drives K on the bus
`timescale 1ns/1ps
`default_nettype none
module usie_device #(
  parameter int IDLE_CYC = usie_pkg::IDLE_SUSPEND_CYC,
  parameter int DEPTH = usie_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic irq_out,
  output logic wakeup_out,
  output logic suspend_out,
  input wire logic ctrl_out_ready_set_in,
  input wire logic ctrl_in_ready_clr_in,
  input wire logic ctrl_stall_set_in,
  input wire logic ctrl_data_end_chg_in,
  usie_if.device link
);
  import usie_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int IW = $clog2(IDLE_CYC + 1);

  logic [1:0] line_m_ff, line_s_ff, line_prev_ff;
  logic oe_m_ff, oe_s_ff;
  logic [7:0] in_csr_ff;
  logic [4:0] event_ff;
  logic [7:0] misc_ff;
  logic [7:0] ctrl_byte_ff;
  logic [7:0] in_mem [DEPTH];
  logic [PW:0] wr_ptr_ff, rd_ptr_ff, sent_ff;
  logic odd_ff;
  logic [IW-1:0] idle_ff;
  logic sending_ff;
  logic [7:0] rdata_ff;
  logic irq_ff, wake_ff;
  logic dev_oe_ff, valid_ff, last_ff, stall_ff, nak_ff;
  logic [7:0] data_ff;
  logic [1:0] dev_line_ff;

  logic bus_reset, wr_csr, wr_misc, wr_fifo, ready_clr, stall_set;
  logic [3:0] maxp;
  logic [PW:0] level;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] r,
                               input logic s);
    return s && (a == r);
  endfunction

  // line pins come from outside: two stages before use
  always_ff @(posedge core_clk_in) begin
    line_m_ff <= link.host_line;
    line_s_ff <= line_m_ff;
    oe_m_ff <= link.host_line_oe;
    oe_s_ff <= oe_m_ff;
    line_prev_ff <= line_s_ff;
  end

  assign bus_reset = oe_s_ff && (line_s_ff == LINE_SE0);
  assign wr_csr = hit(reg_addr_in, ADDR_IN_CSR, reg_wr_in);
  assign wr_misc = hit(reg_addr_in, ADDR_MISC, reg_wr_in);
  assign wr_fifo = hit(reg_addr_in, ADDR_IN_FIFO, reg_wr_in);
  assign maxp = in_csr_ff[IN_MAX_PACKET_SIZE_HI:IN_MAX_PACKET_SIZE_LO];
  assign level = wr_ptr_ff - rd_ptr_ff;
  assign ready_clr = sending_ff && link.in_ack;
  assign stall_set = link.in_violation && !in_csr_ff[IN_STALL_BIT];

  // IN FIFO storage, core write only
  always_ff @(posedge core_clk_in) begin
    if (wr_fifo && level != (PW+1)'(DEPTH)) begin
      in_mem[wr_ptr_ff[PW-1:0]] <= reg_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_ff <= '0;
    end else if (wr_csr && reg_wdata_in[IN_FLUSH_BIT]) begin
      wr_ptr_ff <= rd_ptr_ff;
    end else if (wr_fifo && level != (PW+1)'(DEPTH)) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  // in-packet engine: streams one byte every second cycle after an IN token
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rd_ptr_ff <= '0;
      sent_ff <= '0;
      sending_ff <= 1'b0;
      valid_ff <= 1'b0;
      last_ff <= 1'b0;
      data_ff <= 8'h00;
      stall_ff <= 1'b0;
      nak_ff <= 1'b0;
      odd_ff <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      last_ff <= 1'b0;
      stall_ff <= 1'b0;
      nak_ff <= 1'b0;
      if (wr_csr && reg_wdata_in[IN_FLUSH_BIT]) begin
        sent_ff <= '0;
        sending_ff <= 1'b0;
      end else if (link.in_violation || (link.in_token &&
                   in_csr_ff[IN_STALL_BIT])) begin
        stall_ff <= 1'b1;
      end else if (link.in_token && !sending_ff) begin
        if (!in_csr_ff[IN_READY_BIT]) begin
          nak_ff <= 1'b1;
        end else begin
          sending_ff <= 1'b1;
          sent_ff <= '0;
          // a set force bit overrides the running toggle
          if (in_csr_ff[IN_FORCE_EVEN_BIT]) begin
            odd_ff <= 1'b0;
          end
        end
      end else if (sending_ff && !last_ff && valid_ff == 1'b0 &&
                   sent_ff < (PW+1)'(maxp) && level != '0) begin
        valid_ff <= 1'b1;
        data_ff <= in_mem[rd_ptr_ff[PW-1:0]];
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
        sent_ff <= sent_ff + 1'b1;
        last_ff <= (sent_ff + 1'b1 == (PW+1)'(maxp)) || level == 1;
      end else if (ready_clr) begin
        sending_ff <= 1'b0;
        odd_ff <= !odd_ff;
      end
    end
  end

  // IN control/status register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      in_csr_ff <= IN_CSR_RESET;
    end else begin
      if (wr_csr) begin
        in_csr_ff <= reg_wdata_in;
        in_csr_ff[IN_FLUSH_BIT] <= 1'b0;
      end
      if (link.in_token && sending_ff == 1'b0 && in_csr_ff[IN_READY_BIT]) begin
        in_csr_ff[IN_FORCE_EVEN_BIT] <= 1'b0;
      end
      if (link.in_violation) begin
        in_csr_ff[IN_STALL_BIT] <= 1'b1;
      end
      if (ready_clr) begin
        in_csr_ff[IN_READY_BIT] <= 1'b0;
      end
    end
  end

  // control endpoint byte, written by either side, last writer wins; a link write beats a core write in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl_byte_ff <= 8'h00;
    end else if (link.ctrl_wr) begin
      ctrl_byte_ff <= link.ctrl_wdata;
    end else if (hit(reg_addr_in, ADDR_CTRL_FIFO, reg_wr_in)) begin
      ctrl_byte_ff <= reg_wdata_in;
    end
  end

  // idle counter: any J/K change or host drive counts as activity
  always_ff @(posedge core_clk_in) begin
    // a host that drives even a steady J is still active
    if (sys_rst_in || oe_s_ff || line_s_ff != line_prev_ff) begin
      idle_ff <= '0;
    end else if (idle_ff != IW'(IDLE_CYC)) begin
      idle_ff <= idle_ff + 1'b1;
    end
  end

  // events: hardware set wins over a clear-on-read in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      event_ff <= 5'h00;
    end else begin
      if (hit(reg_addr_in, ADDR_EVENT, reg_rd_in)) begin
        event_ff <= 5'h00;
      end
      if (bus_reset) begin
        event_ff[EV_RESET_BIT] <= 1'b1;
      end
      if (misc_ff[MISC_SUSPEND_BIT] && line_prev_ff == LINE_J &&
          line_s_ff == LINE_K) begin
        event_ff[EV_RESUME_BIT] <= 1'b1;
      end
      if (idle_ff == IW'(IDLE_CYC - 1)) begin
        event_ff[EV_SUSPEND_BIT] <= 1'b1;
      end
      if (ready_clr || stall_set) begin
        event_ff[EV_IN_EP_BIT] <= 1'b1;
      end
      if (ctrl_out_ready_set_in || ctrl_in_ready_clr_in ||
          ctrl_stall_set_in || ctrl_data_end_chg_in) begin
        event_ff[EV_CTRL_EP_BIT] <= 1'b1;
      end
    end
  end

  // misc register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      misc_ff <= MISC_RESET;
    end else begin
      if (wr_misc) begin
        misc_ff[5:0] <= reg_wdata_in[5:0];
      end
      misc_ff[MISC_RST_STAT_BIT] <= bus_reset;
      misc_ff[7] <= 1'b0;
      if (idle_ff == IW'(IDLE_CYC - 1)) begin
        misc_ff[MISC_SUSPEND_BIT] <= 1'b1;
      end
    end
  end

  // outputs
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
      dev_oe_ff <= 1'b0;
      dev_line_ff <= LINE_J;
    end else begin
      unique case (reg_addr_in)
        ADDR_CTRL_FIFO: rdata_ff <= ctrl_byte_ff;
        ADDR_IN_CSR: rdata_ff <= in_csr_ff;
        ADDR_EVENT: rdata_ff <= {3'h0, event_ff};
        ADDR_MISC: rdata_ff <= misc_ff;
        default: rdata_ff <= 8'h00;
      endcase
      irq_ff <= (event_ff[EV_RESET_BIT] && !misc_ff[MISC_MASK_RESET_BIT]) ||
        (event_ff[EV_SUSPEND_BIT] && !misc_ff[MISC_MASK_SUSP_BIT]) ||
        (event_ff[EV_IN_EP_BIT] && !misc_ff[MISC_MASK_IN_BIT]) ||
        (event_ff[EV_CTRL_EP_BIT] && !misc_ff[MISC_MASK_CTRL_BIT]) ||
        event_ff[EV_RESUME_BIT];
      if (!misc_ff[MISC_SUSPEND_BIT]) begin
        wake_ff <= 1'b0;
      end else if (line_prev_ff == LINE_J && line_s_ff == LINE_K) begin
        wake_ff <= 1'b1;
      end
      // drive K while the request is held; idle J before it
      dev_oe_ff <= misc_ff[MISC_RESUME_REQ_BIT];
      dev_line_ff <= misc_ff[MISC_RESUME_REQ_BIT] ? LINE_K : LINE_J;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign irq_out = irq_ff;
  assign wakeup_out = wake_ff;
  assign suspend_out = misc_ff[MISC_SUSPEND_BIT];
  assign link.dev_line = dev_line_ff;
  assign link.dev_line_oe = dev_oe_ff;
  assign link.dev_in_valid = valid_ff;
  assign link.dev_in_data = data_ff;
  assign link.dev_in_last = last_ff;
  assign link.dev_in_pid_odd = odd_ff;
  assign link.dev_in_stall = stall_ff;
  assign link.dev_in_nak = nak_ff;
  assign link.ctrl_rdata = ctrl_byte_ff;
endmodule
`default_nettype wire

// *** logic/usie_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// host end: turns one-cycle user commands into link activity
module usie_host (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic bus_reset_in,
  input wire logic bus_idle_in,
  input wire logic resume_k_in,
  input wire logic in_token_in,
  input wire logic in_ack_in,
  input wire logic violation_in,
  input wire logic ctrl_wr_in,
  input wire logic [7:0] ctrl_wdata_in,
  input wire logic ctrl_rd_in,
  output logic [7:0] ctrl_rdata_out,
  output logic [7:0] in_data_out,
  output logic in_valid_out,
  output logic in_last_out,
  output logic in_odd_out,
  output logic in_stall_out,
  output logic remote_wake_out,
  usie_if.host link
);
  import usie_pkg::*;

  logic [1:0] line_ff;
  logic oe_ff, tok_ff, ack_ff, vio_ff, cwr_ff, crd_ff;
  logic [7:0] cwd_ff, crd_data_ff, dat_ff;
  logic val_ff, last_ff, odd_ff, stl_ff, wake_ff;
  logic [1:0] dl_m_ff, dl_s_ff;

  // device line passes two stages before use
  always_ff @(posedge core_clk_in) begin
    dl_m_ff <= link.dev_line_oe ? link.dev_line : LINE_J;
    dl_s_ff <= dl_m_ff;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      line_ff <= LINE_J;
      oe_ff <= 1'b0;
      tok_ff <= 1'b0;
      ack_ff <= 1'b0;
      vio_ff <= 1'b0;
      cwr_ff <= 1'b0;
      cwd_ff <= 8'h00;
      crd_ff <= 1'b0;
      crd_data_ff <= 8'h00;
      dat_ff <= 8'h00;
      val_ff <= 1'b0;
      last_ff <= 1'b0;
      odd_ff <= 1'b0;
      stl_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      oe_ff <= bus_reset_in || resume_k_in || !bus_idle_in;
      line_ff <= bus_reset_in ? LINE_SE0 : (resume_k_in ? LINE_K : LINE_J);
      tok_ff <= in_token_in;
      ack_ff <= in_ack_in;
      vio_ff <= violation_in;
      cwr_ff <= ctrl_wr_in;
      cwd_ff <= ctrl_wdata_in;
      crd_ff <= ctrl_rd_in;
      if (crd_ff) begin
        crd_data_ff <= link.ctrl_rdata;
      end
      val_ff <= link.dev_in_valid;
      dat_ff <= link.dev_in_data;
      last_ff <= link.dev_in_last;
      odd_ff <= link.dev_in_pid_odd;
      stl_ff <= link.dev_in_stall;
      wake_ff <= dl_s_ff == LINE_K;
    end
  end

  assign link.host_line = line_ff;
  assign link.host_line_oe = oe_ff;
  assign link.in_token = tok_ff;
  assign link.in_ack = ack_ff;
  assign link.in_violation = vio_ff;
  assign link.ctrl_wr = cwr_ff;
  assign link.ctrl_wdata = cwd_ff;
  assign link.ctrl_rd = crd_ff;
  assign ctrl_rdata_out = crd_data_ff;
  assign in_data_out = dat_ff;
  assign in_valid_out = val_ff;
  assign in_last_out = last_ff;
  assign in_odd_out = odd_ff;
  assign in_stall_out = stl_ff;
  assign remote_wake_out = wake_ff;
endmodule
`default_nettype wire

// *** test/usie_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module usie_link_checker (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [1:0] dev_line,
  input wire logic dev_line_oe,
  input wire logic in_token,
  input wire logic in_violation,
  input wire logic dev_in_valid,
  input wire logic dev_in_last,
  input wire logic dev_in_pid_odd,
  input wire logic dev_in_stall,
  input wire logic dev_in_nak
);
  import usie_pkg::*;
  // cycles since the last token or violation, saturating so it never wraps
  logic [2:0] gap_ff;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || in_token || in_violation) begin
      gap_ff <= 3'h0;
    end else if (gap_ff != 3'h7) begin
      gap_ff <= gap_ff + 3'h1;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_stall_nak_excl:
    assert property (!(dev_in_stall && dev_in_nak))
    else $error("stall and nak in one cycle");
  a_handshake_cause:
    assert property ((dev_in_stall || dev_in_nak) |-> gap_ff < 3'h4)
    else $error("handshake without a recent token");
  a_byte_gap:
    assert property (dev_in_valid |=> !dev_in_valid)
    else $error("in bytes closer than two cycles");
  a_byte_cadence:
    assert property (dev_in_valid && !dev_in_last |=> !dev_in_valid ##1 dev_in_valid)
    else $error("in packet broke its byte cadence");
  a_last_is_byte:
    assert property (dev_in_last |-> dev_in_valid)
    else $error("last flag without a byte");
  a_toggle_steady:
    assert property (dev_in_valid && !dev_in_last |->
      ##2 (dev_in_pid_odd == $past(dev_in_pid_odd, 2)))
    else $error("toggle changed inside a packet");
  a_no_data_hs:
    assert property (dev_in_valid |-> !(dev_in_stall || dev_in_nak))
    else $error("handshake during a data byte");
  a_reset_idle:
    assert property ($fell(sys_rst_in) |-> !dev_line_oe && dev_line == LINE_J)
    else $error("device line not idle after reset");
  a_drive_is_k:
    assert property (dev_line_oe |-> dev_line == LINE_K)
    else $error("device drives other than K");
endmodule
`default_nettype wire

// *** test/usie_sie_in_endpoint_and_interrupt_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module usie_sie_in_endpoint_and_interrupt_regs_test;
  import usie_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] ra = 3'h0;
  logic [7:0] wd = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [8:0] pv = 9'h000;
  logic [7:0] cw = 8'h00;
  logic brst = 1'b0;
  logic bidle = 1'b0;
  logic rk = 1'b0;
  wire logic [7:0] rdata, crd, ind;
  wire logic irq, wake, susp, inv, inl, ino, ins, rwk;
  int miscompares = 0;
  int n_tests = 0;
  usie_if lk();
  // short idle count keeps the suspend scenarios brief
  usie_device #(.IDLE_CYC(50)) u_usie_device (.core_clk_in(clk),
    .sys_rst_in(rst), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(we), .reg_rd_in(re), .reg_rdata_out(rdata),
    .irq_out(irq), .wakeup_out(wake), .suspend_out(susp),
    .ctrl_out_ready_set_in(pv[5]), .ctrl_in_ready_clr_in(pv[6]),
    .ctrl_stall_set_in(pv[7]), .ctrl_data_end_chg_in(pv[8]), .link(lk));
  usie_host u_usie_host (.core_clk_in(clk), .sys_rst_in(rst),
    .bus_reset_in(brst), .bus_idle_in(bidle), .resume_k_in(rk),
    .in_token_in(pv[0]), .in_ack_in(pv[1]), .violation_in(pv[2]),
    .ctrl_wr_in(pv[3]), .ctrl_wdata_in(cw), .ctrl_rd_in(pv[4]),
    .ctrl_rdata_out(crd), .in_data_out(ind), .in_valid_out(inv),
    .in_last_out(inl), .in_odd_out(ino), .in_stall_out(ins),
    .remote_wake_out(rwk), .link(lk));
  usie_link_checker u_usie_link_checker (.core_clk_in(clk),
    .sys_rst_in(rst), .dev_line(lk.dev_line),
    .dev_line_oe(lk.dev_line_oe), .in_token(lk.in_token),
    .in_violation(lk.in_violation), .dev_in_valid(lk.dev_in_valid),
    .dev_in_last(lk.dev_in_last), .dev_in_pid_odd(lk.dev_in_pid_odd),
    .dev_in_stall(lk.dev_in_stall), .dev_in_nak(lk.dev_in_nak));
  always #4 clk = ~clk;
  task final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // mask 0 only clears the event flags, since a read empties them
  task rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    ra <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task pulse(input int i);
    @(posedge clk);
    pv[i] <= 1'b1;
    @(posedge clk);
    pv[i] <= 1'b0;
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return susp;
      1: return wake;
      2: return rwk;
      3: return ins;
      default: return lk.dev_in_nak;
    endcase
  endfunction
  // one-cycle pulses are seen once: values are read before the edge lands
  task poll(input int k);
    int i;
    for (i = 0; i < 300 && sel(k) !== 1'b1; i++) begin
      @(posedge clk);
    end
    n_tests++;
    if (i == 300) begin
      miscompares++;
      final_report();
    end
  endtask
  task pkt(input int n, input logic odd, input logic [7:0] b0);
    int c;
    int i;
    c = 0;
    pulse(0);
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (inv === 1'b1) begin
        chk(ind, b0 + 8'(c));
        chk(8'(ino), 8'(odd));
        c++;
        if (inl === 1'b1) break;
      end
    end
    if (i == 60) begin
      miscompares++;
      final_report();
    end
    chk(8'(c), 8'(n));
    pulse(1);
    tick(3);
  endtask
  task t_reset();
    rdc(ADDR_IN_CSR, 8'hFF, 8'h20);
    rdc(ADDR_MISC, 8'hFF, 8'h10);
    rdc(ADDR_EVENT, 8'hFF, 8'h00);
    chk(8'(irq), 8'h00);
  endtask
  task t_ctrl();
    @(posedge clk);
    cw <= 8'hA5;
    pulse(3);
    tick(2);
    rdc(ADDR_CTRL_FIFO, 8'hFF, 8'hA5);
    wr(ADDR_CTRL_FIFO, 8'h3C);
    pulse(4);
    tick(3);
    chk(crd, 8'h3C);
  endtask
  task t_cev();
    int i;
    wr(ADDR_MISC, 8'h00);
    rdc(ADDR_EVENT, 8'h00, 8'h00);
    for (i = 5; i < 9; i++) begin
      pulse(i);
      tick(3);
      chk(8'(irq), 8'h01);
      rdc(ADDR_EVENT, 8'hFF, 8'h01);
      tick(3);
      chk(8'(irq), 8'h00);
    end
    wr(ADDR_MISC, 8'h04);
    pulse(5);
    tick(3);
    chk(8'(irq), 8'h00);
    rdc(ADDR_EVENT, 8'hFF, 8'h01);
  endtask
  task t_in();
    int i;
    for (i = 0; i < 3; i++) begin
      wr(ADDR_IN_FIFO, 8'h10 + 8'(i));
    end
    wr(ADDR_IN_CSR, 8'h09);
    pkt(2, 1'b0, 8'h10);
    rdc(ADDR_IN_CSR, 8'h01, 8'h00);
    rdc(ADDR_EVENT, 8'h02, 8'h02);
    wr(ADDR_IN_CSR, 8'h49);
    pkt(1, 1'b0, 8'h12);
    rdc(ADDR_IN_CSR, 8'h40, 8'h00);
    wr(ADDR_IN_FIFO, 8'h20);
    wr(ADDR_IN_CSR, 8'h09);
    pkt(1, 1'b1, 8'h20);
  endtask
  task t_flush();
    wr(ADDR_IN_FIFO, 8'h30);
    wr(ADDR_IN_FIFO, 8'h31);
    wr(ADDR_IN_CSR, 8'h88);
    rdc(ADDR_IN_CSR, 8'h80, 8'h00);
    wr(ADDR_IN_FIFO, 8'h40);
    wr(ADDR_IN_CSR, 8'h09);
    pkt(1, 1'b0, 8'h40);
    pulse(0);
    poll(4);
  endtask
  task t_stall();
    rdc(ADDR_EVENT, 8'h00, 8'h00);
    pulse(2);
    tick(3);
    rdc(ADDR_IN_CSR, 8'h02, 8'h02);
    rdc(ADDR_EVENT, 8'h02, 8'h02);
    pulse(0);
    poll(3);
    wr(ADDR_IN_CSR, 8'h08);
    rdc(ADDR_IN_CSR, 8'h02, 8'h00);
  endtask
  task t_brst();
    wr(ADDR_MISC, 8'h40);
    rdc(ADDR_MISC, 8'h40, 8'h00);
    rdc(ADDR_EVENT, 8'h00, 8'h00);
    @(posedge clk);
    brst <= 1'b1;
    tick(8);
    rdc(ADDR_MISC, 8'h40, 8'h40);
    @(posedge clk);
    brst <= 1'b0;
    tick(8);
    rdc(ADDR_MISC, 8'h40, 8'h00);
    chk(8'(irq), 8'h01);
    wr(ADDR_MISC, 8'h38);
    tick(2);
    chk(8'(irq), 8'h00);
    rdc(ADDR_EVENT, 8'h10, 8'h10);
  endtask
  task t_susp();
    rdc(ADDR_EVENT, 8'h00, 8'h00);
    @(posedge clk);
    bidle <= 1'b1;
    tick(40);
    chk(8'(susp), 8'h00);
    poll(0);
    rdc(ADDR_MISC, 8'h01, 8'h01);
    rdc(ADDR_EVENT, 8'h04, 8'h04);
    @(posedge clk);
    bidle <= 1'b0;
    rk <= 1'b1;
    poll(1);
    @(posedge clk);
    rk <= 1'b0;
    rdc(ADDR_EVENT, 8'h08, 8'h08);
    wr(ADDR_MISC, 8'h00);
    tick(3);
    chk({6'h00, wake, susp}, 8'h00);
  endtask
  task t_rwake();
    @(posedge clk);
    bidle <= 1'b1;
    poll(0);
    wr(ADDR_MISC, 8'h03);
    poll(2);
    wr(ADDR_MISC, 8'h00);
    @(posedge clk);
    bidle <= 1'b0;
    tick(5);
  endtask
  initial begin
    tick(2);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_cev();
    t_in();
    t_flush();
    t_stall();
    t_brst();
    t_susp();
    t_rwake();
    final_report();
  end
endmodule
`default_nettype wire
